// ===== csm_pkg.sv
// Package for the core special-state block: register layouts, memory
// types, attribute decode constants and the carrier structs.
// Assumes the core pipeline drives instruction events on the same clock.
package csm_pkg;

  // ==========================================================
  // Field positions and reset values
  localparam int unsigned TBIT_POS = 24;
  localparam int unsigned MASK_POS = 0;
  localparam int unsigned SPSEL_POS = 1;
  localparam logic MASK_RESET = 1'h0;
  localparam logic SPSEL_RESET = 1'h0;
  localparam logic TBIT_RESET = 1'h1;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ==========================================================
  // Special register selectors for the move instructions
  typedef enum logic [1:0] {
    CSM_SEL_EXEC = 2'b00,
    CSM_SEL_MASK = 2'b01,
    CSM_SEL_CTRL = 2'b10,
    CSM_SEL_NONE = 2'b11
  } csm_sel_type;

  // ==========================================================
  // Memory types and access sizes
  typedef enum logic [1:0] {
    CSM_MEM_NORMAL = 2'b00,
    CSM_MEM_DEVICE = 2'b01,
    CSM_MEM_STRONG = 2'b10
  } csm_mem_type;

  typedef enum logic [1:0] {
    CSM_SZ_BYTE = 2'b00,
    CSM_SZ_HALF = 2'b01,
    CSM_SZ_WORD = 2'b10
  } csm_size_type;

  // Region boundaries, upper address nibble/field
  localparam logic [3:0] REG_PERIPH_LO = 4'h4;
  localparam logic [3:0] REG_PERIPH_HI = 4'h5;
  localparam logic [3:0] REG_XDEV_LO = 4'ha;
  localparam logic [3:0] REG_XDEV_HI = 4'hd;
  localparam logic [3:0] REG_SYS = 4'he;
  localparam logic [7:0] PPB_TOP_BYTE = 8'he0;
  localparam logic [3:0] PPB_NIB = 4'h0;

  // Multi-step instruction states
  typedef enum logic [1:0] {
    CSM_ST_IDLE = 2'b00,
    CSM_ST_BUSY = 2'b01,
    CSM_ST_RESTART = 2'b10
  } csm_state_type;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
    logic fetch;
    csm_size_type size;
    logic [31:0] wdata;
  } csm_mreq_type;

  typedef struct packed {
    logic valid;
    csm_mem_type mtype;
    logic shareable;
    logic bufferable;
    logic reorder_ok;
    logic ordered;
    logic [3:0] lanes;
    logic [31:0] data;
  } csm_mresp_type;

  typedef struct packed {
    logic tbit;
    logic mask;
    logic spsel;
    logic handler;
    csm_state_type mstate;
    logic [31:0] rd_data;
    logic hard_fault;
    logic restart;
    logic except_block;
    logic use_psp;
    csm_mresp_type mresp;
  } csm_regs_type;

endpackage : csm_pkg

// ===== csm_core_state.sv
// Core special-state logic: instruction-set state bit, exception mask,
// stack select, restartable multi-step instructions, memory attributes.
// Assumes single clock, events from the pipeline, one event per kind per cycle.
// Summary of operation
// - Reading execution state word returns zero
// - Writes to execution state word do nothing
// - State bit updated by branches, pops, exceptions
// - State bit zero on execute raises fault
// - Interrupt abandons multi-register or iterative multiply
// - Abandoned instruction restarts from first step
// - Mask bit one blocks configurable-priority exceptions
// - Mask bit via move and change-state instructions
// - Control bit one selects process stack
// - Handler mode: select bit reads zero, ignores writes
// - Handler mode always uses main stack
// - Exception entry sets handler mode only; return updates mode and control
// - Out of reset thread uses main stack
// - Every exception but reset runs in handler
// - Word, halfword and byte accesses supported
// - Fetch and private bus always little-endian
// - Normal memory may reorder and speculate
// - Device memory ordered against device, strong
// - Strongly-ordered keeps all order, is shareable
// - Device writes bufferable, strongly-ordered never
// - Fetch from no-execute region raises fault
// - State bit is bit 24, loaded from vector
// - Select bit resets to zero
`timescale 1ns/1ps

module csm_core_state #(
  parameter bit BIG_ENDIAN = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic rst_vec_valid,
  input wire logic [31:0] rst_vec,
  input wire logic spr_rd,
  input wire logic spr_wr,
  input wire csm_pkg::csm_sel_type spr_sel,
  input wire logic [31:0] spr_wdata,
  input wire logic cps_set,
  input wire logic cps_clr,
  input wire logic branch_exchange,
  input wire logic [31:0] branch_target,
  input wire logic exc_entry,
  input wire logic [31:0] exc_vector,
  input wire logic exc_return,
  input wire logic [31:0] stacked_status,
  input wire logic return_to_thread,
  input wire logic return_spsel,
  input wire logic instr_exec,
  input wire logic fetch_xn,
  input wire logic multi_start,
  input wire logic multi_done,
  input wire logic irq_arrive,
  input wire csm_pkg::csm_mreq_type mreq,
  output logic tbit,
  output logic mask_bit,
  output logic spsel_bit,
  output logic handler_mode,
  output logic [31:0] spr_rdata,
  output logic hard_fault,
  output logic multi_abandon,
  output logic multi_restart,
  output logic except_block,
  output logic use_psp,
  output csm_pkg::csm_mresp_type mresp
);

  // ==========================================================
  // Region decode, used by attribute logic only; fetch fault comes from fetch_xn
  function automatic csm_pkg::csm_mem_type region_type(input logic [31:0] a);
    logic [3:0] nib;
    nib = a[31:28];
    if ((nib >= csm_pkg::REG_PERIPH_LO && nib <= csm_pkg::REG_PERIPH_HI) ||
        (nib >= csm_pkg::REG_XDEV_LO && nib <= csm_pkg::REG_XDEV_HI))
      return csm_pkg::CSM_MEM_DEVICE;
    else if (nib == csm_pkg::REG_SYS && a[27:20] == {csm_pkg::PPB_NIB, csm_pkg::PPB_NIB})
      return csm_pkg::CSM_MEM_STRONG;
    else if (nib >= csm_pkg::REG_SYS)
      return csm_pkg::CSM_MEM_DEVICE;
    else
      return csm_pkg::CSM_MEM_NORMAL;
  endfunction : region_type

  function automatic logic is_ppb(input logic [31:0] a);
    return a[31:24] == csm_pkg::PPB_TOP_BYTE && a[23:20] == csm_pkg::PPB_NIB;
  endfunction : is_ppb

  csm_pkg::csm_regs_type st_ff;
  csm_pkg::csm_regs_type nxt_st;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    csm_pkg::csm_mem_type mt;
    logic little;
    logic [31:0] wd;
    mt = region_type(mreq.addr);
    little = 1'b0;
    wd = csm_pkg::ZERO_WORD;
    nxt_st = st_ff;
    nxt_st.rd_data = csm_pkg::ZERO_WORD;
    nxt_st.hard_fault = 1'b0;
    nxt_st.restart = 1'b0;

    // Reset vector bit 0 lands in the state bit
    if (rst_vec_valid)
      nxt_st.tbit = rst_vec[0];

    // State bit sources; later lines win, exception flow dominates
    if (branch_exchange)
      nxt_st.tbit = branch_target[0];
    if (exc_return)
      nxt_st.tbit = stacked_status[csm_pkg::TBIT_POS];
    if (exc_entry)
      nxt_st.tbit = exc_vector[0];

    // Mode and stack selection through exception flow
    if (exc_entry)
    begin
      nxt_st.handler = 1'b1;
    end
    else if (exc_return)
    begin
      nxt_st.handler = !return_to_thread;
      nxt_st.spsel = return_to_thread ? return_spsel : 1'b0;
    end

    // Special register writes; exec word writes are dropped
    if (spr_wr && spr_sel == csm_pkg::CSM_SEL_MASK)
      nxt_st.mask = spr_wdata[csm_pkg::MASK_POS];
    if (spr_wr && spr_sel == csm_pkg::CSM_SEL_CTRL && !st_ff.handler && !exc_entry)
      nxt_st.spsel = spr_wdata[csm_pkg::SPSEL_POS];
    // CSM_SEL_EXEC write: nothing changes
    if (cps_set)
      nxt_st.mask = 1'b1;
    else if (cps_clr)
      nxt_st.mask = 1'b0;

    // Reads; reserved bits and exec word read zero
    if (spr_rd)
    begin
      case (spr_sel)
        csm_pkg::CSM_SEL_MASK: nxt_st.rd_data[csm_pkg::MASK_POS] = st_ff.mask;
        csm_pkg::CSM_SEL_CTRL:
          nxt_st.rd_data[csm_pkg::SPSEL_POS] = st_ff.spsel & !st_ff.handler;
        csm_pkg::CSM_SEL_EXEC: nxt_st.rd_data = csm_pkg::ZERO_WORD;
        default: nxt_st.rd_data = csm_pkg::ZERO_WORD;
      endcase
    end

    // Execution faults: state bit clear or no-execute fetch
    if (instr_exec && (!st_ff.tbit || fetch_xn))
      nxt_st.hard_fault = 1'b1;

    // Multi-step instructions: abandon on interrupt, restart whole
    case (st_ff.mstate)
      csm_pkg::CSM_ST_IDLE:
        if (multi_start && !irq_arrive)
          nxt_st.mstate = csm_pkg::CSM_ST_BUSY;
      csm_pkg::CSM_ST_BUSY:
        if (irq_arrive)
          nxt_st.mstate = csm_pkg::CSM_ST_RESTART;
        else if (multi_done)
          nxt_st.mstate = csm_pkg::CSM_ST_IDLE;
      csm_pkg::CSM_ST_RESTART:
        if (exc_return)
        begin
          nxt_st.mstate = csm_pkg::CSM_ST_IDLE;
          nxt_st.restart = 1'b1;
        end
      default: nxt_st.mstate = csm_pkg::CSM_ST_IDLE;
    endcase

    // Derived mask and stack outputs
    nxt_st.except_block = nxt_st.mask;
    nxt_st.use_psp = nxt_st.spsel & !nxt_st.handler;

    // Memory attributes and lanes, registered one cycle later
    nxt_st.mresp.valid = mreq.valid;
    nxt_st.mresp.mtype = mt;
    nxt_st.mresp.reorder_ok = mt == csm_pkg::CSM_MEM_NORMAL;
    nxt_st.mresp.ordered = mt != csm_pkg::CSM_MEM_NORMAL;
    nxt_st.mresp.shareable = mt == csm_pkg::CSM_MEM_STRONG;
    nxt_st.mresp.bufferable = mreq.write && mt != csm_pkg::CSM_MEM_STRONG;
    little = !BIG_ENDIAN || mreq.fetch || is_ppb(mreq.addr);
    case (mreq.size)
      csm_pkg::CSM_SZ_BYTE: nxt_st.mresp.lanes = 4'h1 << mreq.addr[1:0];
      csm_pkg::CSM_SZ_HALF: nxt_st.mresp.lanes = mreq.addr[1] ? 4'hc : 4'h3;
      default: nxt_st.mresp.lanes = 4'hf;
    endcase
    // Big-endian swaps bytes inside the word; byte-invariant addressing
    wd = little ? mreq.wdata :
      {mreq.wdata[7:0], mreq.wdata[15:8], mreq.wdata[23:16], mreq.wdata[31:24]};
    nxt_st.mresp.data = wd;
  end

  // ==========================================================
  // State register; clk_en freezes everything
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_ff <= '0;
      st_ff.tbit <= csm_pkg::TBIT_RESET;
      st_ff.mask <= csm_pkg::MASK_RESET;
      st_ff.spsel <= csm_pkg::SPSEL_RESET;
      st_ff.mstate <= csm_pkg::CSM_ST_IDLE;
    end
    else if (clk_en)
      st_ff <= nxt_st;
  end

  assign tbit = st_ff.tbit;
  assign mask_bit = st_ff.mask;
  assign spsel_bit = st_ff.spsel;
  assign handler_mode = st_ff.handler;
  assign spr_rdata = st_ff.rd_data;
  assign hard_fault = st_ff.hard_fault;
  assign multi_abandon = st_ff.mstate == csm_pkg::CSM_ST_RESTART;
  assign multi_restart = st_ff.restart;
  assign except_block = st_ff.except_block;
  assign use_psp = st_ff.use_psp;
  assign mresp = st_ff.mresp;

  // ==========================================================
  // Assertions
  a_exec_read_zero: assert property (@(posedge clk) disable iff (reset)
    clk_en && spr_rd && spr_sel == csm_pkg::CSM_SEL_EXEC |=> spr_rdata == csm_pkg::ZERO_WORD)
    else $error("exec word read not zero");
  a_exec_write_none: assert property (@(posedge clk) disable iff (reset)
    clk_en && spr_wr && spr_sel == csm_pkg::CSM_SEL_EXEC && !cps_set && !cps_clr
    |=> $stable(mask_bit))
    else $error("exec word write changed mask");
  a_tbit_fault: assert property (@(posedge clk) disable iff (reset)
    clk_en && instr_exec && !tbit |=> hard_fault)
    else $error("no fault with state bit clear");
  a_xn_fault: assert property (@(posedge clk) disable iff (reset)
    clk_en && instr_exec && fetch_xn |=> hard_fault)
    else $error("no fault on no-execute fetch");
  a_handler_msp: assert property (@(posedge clk) disable iff (reset)
    handler_mode |-> !use_psp)
    else $error("process stack used in handler");
  a_handler_ignore: assert property (@(posedge clk) disable iff (reset)
    clk_en && handler_mode && spr_wr && spr_sel == csm_pkg::CSM_SEL_CTRL && !exc_return
    |=> $stable(spsel_bit))
    else $error("select write taken in handler");
  a_entry_handler: assert property (@(posedge clk) disable iff (reset)
    clk_en && exc_entry |=> handler_mode && tbit == $past(exc_vector[0]))
    else $error("entry did not enter handler");
  a_mask_block: assert property (@(posedge clk) disable iff (reset)
    clk_en && cps_set |=> mask_bit && except_block)
    else $error("mask set did not block");
  a_strong_nobuf: assert property (@(posedge clk) disable iff (reset)
    mresp.valid && mresp.mtype == csm_pkg::CSM_MEM_STRONG |-> !mresp.bufferable && mresp.shareable)
    else $error("strongly-ordered write buffered");
  a_abandon_restart: assert property (@(posedge clk) disable iff (reset)
    clk_en && multi_abandon == 1'b0 && st_ff.mstate == csm_pkg::CSM_ST_BUSY && irq_arrive
    |=> multi_abandon)
    else $error("interrupt did not abandon");
  a_branch_tbit: assert property (@(posedge clk) disable iff (reset)
    clk_en && branch_exchange && !exc_entry && !exc_return |=> tbit == $past(branch_target[0]))
    else $error("branch did not load state bit");
  a_return_tbit: assert property (@(posedge clk) disable iff (reset)
    clk_en && exc_return && !exc_entry |=> tbit == $past(stacked_status[csm_pkg::TBIT_POS]))
    else $error("return did not restore state bit");
  a_vector_tbit: assert property (@(posedge clk) disable iff (reset)
    clk_en && rst_vec_valid && !branch_exchange && !exc_entry && !exc_return
    |=> tbit == $past(rst_vec[0]))
    else $error("reset vector did not load state bit");
  a_restart_whole: assert property (@(posedge clk) disable iff (reset)
    clk_en && multi_abandon && exc_return |=> multi_restart && !multi_abandon)
    else $error("abandoned instruction not restarted");
  a_cps_clear: assert property (@(posedge clk) disable iff (reset)
    clk_en && cps_clr && !cps_set |=> !mask_bit && !except_block)
    else $error("change-state clear left mask set");
  a_mask_read: assert property (@(posedge clk) disable iff (reset)
    clk_en && spr_rd && spr_sel == csm_pkg::CSM_SEL_MASK
    |=> spr_rdata == (32'($past(mask_bit)) << csm_pkg::MASK_POS))
    else $error("mask read wrong");
  a_thread_select: assert property (@(posedge clk) disable iff (reset)
    clk_en && !handler_mode && !exc_entry && !exc_return && spr_wr
    && spr_sel == csm_pkg::CSM_SEL_CTRL
    |=> spsel_bit == $past(spr_wdata[csm_pkg::SPSEL_POS]) && use_psp == spsel_bit)
    else $error("thread stack select not taken");
  a_return_control: assert property (@(posedge clk) disable iff (reset)
    clk_en && exc_return && !exc_entry && return_to_thread && !spr_wr
    |=> !handler_mode && spsel_bit == $past(return_spsel))
    else $error("return did not update control");
  a_ctrl_reserved: assert property (@(posedge clk) disable iff (reset)
    clk_en && spr_rd && spr_sel == csm_pkg::CSM_SEL_CTRL
    |=> (spr_rdata & ~(32'h1 << csm_pkg::SPSEL_POS)) == csm_pkg::ZERO_WORD)
    else $error("control reserved bits not zero");
  // Attribute checks decode the address themselves, so a broken decode shows
  a_word_lanes: assert property (@(posedge clk) disable iff (reset)
    clk_en && mreq.valid && mreq.size == csm_pkg::CSM_SZ_WORD |=> mresp.lanes == 4'hf)
    else $error("word access lanes wrong");
  a_normal_reorder: assert property (@(posedge clk) disable iff (reset)
    clk_en && mreq.valid && mreq.addr[31:30] == 2'h0 |=> mresp.reorder_ok && !mresp.ordered)
    else $error("normal access not reorderable");
  a_device_order: assert property (@(posedge clk) disable iff (reset)
    clk_en && mreq.valid && mreq.addr[31:28] == csm_pkg::REG_PERIPH_LO
    |=> mresp.mtype == csm_pkg::CSM_MEM_DEVICE && mresp.ordered && !mresp.reorder_ok)
    else $error("device access not ordered");
  a_ppb_strong: assert property (@(posedge clk) disable iff (reset)
    clk_en && mreq.valid && mreq.addr[31:24] == csm_pkg::PPB_TOP_BYTE
    && mreq.addr[23:20] == csm_pkg::PPB_NIB
    |=> mresp.mtype == csm_pkg::CSM_MEM_STRONG && mresp.shareable && mresp.ordered)
    else $error("private bus region not strongly ordered");
  a_little_data: assert property (@(posedge clk) disable iff (reset)
    clk_en && mreq.valid && (!BIG_ENDIAN || mreq.fetch) |=> mresp.data == $past(mreq.wdata))
    else $error("little-endian data altered");

endmodule : csm_core_state

// ===== csm_testbench.sv
// Self-checking bench for the core special-state block.
// Assumes csm_pkg and csm_core_state are compiled first; one 40 MHz clock.
`timescale 1ns/1ps

module testbench;
  // ==========================================================
  // Notes, pulse positions and signals
  typedef struct {int k; logic [31:0] m; logic [31:0] v;} csm_note_type;
  localparam logic [11:0] P_RD = 12'h800;
  localparam logic [11:0] P_WR = 12'h400;
  localparam logic [11:0] P_CS = 12'h200;
  localparam logic [11:0] P_CC = 12'h100;
  localparam logic [11:0] P_BX = 12'h080;
  localparam logic [11:0] P_EN = 12'h040;
  localparam logic [11:0] P_RT = 12'h020;
  localparam logic [11:0] P_EX = 12'h010;
  localparam logic [11:0] P_MS = 12'h008;
  localparam logic [11:0] P_MD = 12'h004;
  localparam logic [11:0] P_IQ = 12'h002;
  localparam logic [11:0] P_RV = 12'h001;
  logic clk, reset, clk_en, rst_vec_valid, spr_rd, spr_wr, cps_set, cps_clr;
  logic branch_exchange, exc_entry, exc_return, return_to_thread, return_spsel;
  logic instr_exec, fetch_xn, multi_start, multi_done, irq_arrive;
  logic [31:0] rst_vec, spr_wdata, branch_target, exc_vector, stacked_status;
  csm_pkg::csm_sel_type spr_sel;
  csm_pkg::csm_mreq_type mreq;
  logic tbit, mask_bit, spsel_bit, handler_mode, hard_fault, multi_abandon;
  logic multi_restart, except_block, use_psp;
  logic [31:0] spr_rdata;
  csm_pkg::csm_mresp_type mresp;
  int errors;
  int num_checks;
  logic [31:0] seed, r;
  logic [7:0] cur;
  logic [1:0] s, off, t;
  logic [3:0] ln;
  csm_note_type q[$];
  csm_note_type n;
  logic [31:0] base [7] = '{32'h0000_0000, 32'h2000_0000, 32'h4000_0000, 32'h6000_0000,
    32'ha000_0000, 32'he000_0000, 32'he010_0000};
  logic [1:0] tp [7] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h1};

  csm_core_state uut (.clk, .reset, .clk_en, .rst_vec_valid, .rst_vec, .spr_rd, .spr_wr,
    .spr_sel, .spr_wdata, .cps_set, .cps_clr, .branch_exchange, .branch_target, .exc_entry,
    .exc_vector, .exc_return, .stacked_status, .return_to_thread, .return_spsel, .instr_exec,
    .fetch_xn, .multi_start, .multi_done, .irq_arrive, .mreq, .tbit, .mask_bit, .spsel_bit,
    .handler_mode, .spr_rdata, .hard_fault, .multi_abandon, .multi_restart, .except_block,
    .use_psp, .mresp);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic note(input int k, input logic [31:0] m, input logic [31:0] v);
    q.push_back('{k, m, v});
  endtask : note

  // Pulses set once per falling edge, so nothing is driven twice in a step
  task automatic tick(input logic [11:0] p, input logic [7:0] e);
    {spr_rd, spr_wr, cps_set, cps_clr, branch_exchange, exc_entry, exc_return, instr_exec,
      multi_start, multi_done, irq_arrive, rst_vec_valid} = p;
    cur = e & 8'heb;
    note(0, 32'h0000_00ff, {24'h0, e});
    @(negedge clk);
  endtask : tick

  task automatic rd(input csm_pkg::csm_sel_type sel, input logic [31:0] v);
    spr_sel = sel;
    note(1, 32'hffff_ffff, v);
    tick(P_RD, cur);
  endtask : rd

  task automatic wr(input csm_pkg::csm_sel_type sel, input logic [31:0] v, input logic [7:0] e);
    spr_sel = sel;
    spr_wdata = v;
    tick(P_WR, e);
  endtask : wr

  task automatic cmp(input string nm, input logic [31:0] m, input logic [31:0] e,
    input logic [31:0] g);
    num_checks++;
    if ((g & m) !== (e & m))
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e & m, g & m);
    end
  endtask : cmp

  task automatic give_verdict();
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Clock and watchdog; the run needs about 52 cycles
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    repeat (2000) @(posedge clk);
    errors++;
    give_verdict();
  end

  // Monitor: outputs settle 2 ns after the edge that answers each note
  initial
  begin
    forever
    begin
      @(posedge clk);
      #2;
      while (q.size() > 0)
      begin
        n = q.pop_front();
        if (n.k == 0)
          cmp("state", n.m, n.v, {24'h0, tbit, mask_bit, handler_mode, hard_fault,
            multi_abandon, multi_restart, except_block, use_psp});
        else if (n.k == 1)
          cmp("rdata", n.m, n.v, spr_rdata);
        else if (n.k == 2)
          cmp("mresp", n.m, n.v, {21'h0, mresp.valid, mresp.mtype, mresp.shareable,
            mresp.bufferable, mresp.reorder_ok, mresp.ordered, mresp.lanes});
        else if (n.k == 3)
          cmp("spsel", n.m, n.v, {31'h0, spsel_bit});
        else
          cmp("mdata", n.m, n.v, mresp.data);
      end
    end
  end

  // ==========================================================
  // Stimulus
  initial
  begin
    seed = 32'h0000_3d09;
    errors = 0;
    num_checks = 0;
    {clk_en, reset} = 2'h3;
    {spr_rd, spr_wr, cps_set, cps_clr, branch_exchange, exc_entry, exc_return} = 7'h00;
    {instr_exec, multi_start, multi_done, irq_arrive, rst_vec_valid} = 5'h00;
    {return_to_thread, return_spsel, fetch_xn} = 3'h0;
    {rst_vec, spr_wdata, branch_target, exc_vector, stacked_status} = '0;
    spr_sel = csm_pkg::CSM_SEL_NONE;
    mreq = '0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    tick(12'h000, 8'h80);
    rd(csm_pkg::CSM_SEL_CTRL, 32'h0000_0000);
    rd(csm_pkg::CSM_SEL_EXEC, 32'h0000_0000);
    wr(csm_pkg::CSM_SEL_EXEC, rnd(), 8'h80);
    wr(csm_pkg::CSM_SEL_MASK, rnd() | 32'h1, 8'hc2);
    rd(csm_pkg::CSM_SEL_MASK, 32'h0000_0001);
    wr(csm_pkg::CSM_SEL_MASK, rnd() & 32'hffff_fffe, 8'h80);
    tick(P_CS, 8'hc2);
    tick(P_CC, 8'h80);
    tick(P_CS | P_CC, 8'hc2);
    tick(P_CC, 8'h80);
    note(3, 32'h0000_0001, 32'h0000_0001);
    wr(csm_pkg::CSM_SEL_CTRL, rnd() | 32'h2, 8'h81);
    rd(csm_pkg::CSM_SEL_CTRL, 32'h0000_0002);
    exc_vector = rnd() | 32'h1;
    tick(P_EN, 8'ha0);
    rd(csm_pkg::CSM_SEL_CTRL, 32'h0000_0000);
    wr(csm_pkg::CSM_SEL_CTRL, 32'h0000_0002, 8'ha0);
    stacked_status = rnd() | 32'h0100_0000;
    {return_to_thread, return_spsel} = 2'h3;
    tick(P_RT, 8'h81);
    wr(csm_pkg::CSM_SEL_CTRL, 32'h0000_0000, 8'h80);
    // Instruction-set state bit sources and the faults it gates
    branch_target = rnd() & 32'hffff_fffe;
    tick(P_BX, 8'h00);
    tick(P_EX, 8'h10);
    branch_target = rnd() | 32'h1;
    tick(P_BX, 8'h80);
    fetch_xn = 1'b1;
    tick(P_EX, 8'h90);
    fetch_xn = 1'b0;
    tick(P_EX, 8'h80);
    exc_vector = rnd() & 32'hffff_fffe;
    tick(P_EN, 8'h20);
    return_spsel = 1'b0;
    tick(P_RT, 8'h80);
    rst_vec = rnd() & 32'hffff_fffe;
    tick(P_RV, 8'h00);
    tick(P_BX | P_RV, 8'h80);
    // Attribute decode over every region, sizes cycling byte, half, word
    for (int i = 0; i < 7; i++)
    begin
      r = rnd();
      s = 2'(i % 3);
      off = (s == 2'h0) ? r[1:0] : (s == 2'h1) ? {r[1], 1'b0} : 2'h0;
      ln = (s == 2'h2) ? 4'hf : (s == 2'h1) ? 4'h3 << off : 4'h1 << off;
      t = tp[i];
      mreq = '{1'b1, base[i] | (r & 32'h000f_fff0) | 32'(off), r[8], 1'b0,
        csm_pkg::csm_size_type'(s), rnd()};
      note(4, 32'hffff_ffff, mreq.wdata);
      note(2, (t == 2'h2) ? 32'h0000_07ff : (t == 2'h1) ? 32'h0000_073f : 32'h0000_072f,
        {21'h0, 1'b1, t, t == 2'h2, 1'b0, t == 2'h0, t != 2'h0, ln});
      tick(12'h000, 8'h80);
    end
    mreq = '0;
    // Abandon on interrupt, then restart after the return
    tick(P_MS, 8'h80);
    tick(12'h000, 8'h80);
    tick(P_IQ, 8'h88);
    exc_vector = rnd() | 32'h1;
    tick(P_EN, 8'ha8);
    tick(P_RT, 8'h84);
    tick(P_MD, 8'h80);
    tick(P_IQ, 8'h80);
    // Second reset in mid-run clears mask and stack select at once
    wr(csm_pkg::CSM_SEL_CTRL, 32'h0000_0002, 8'h81);
    tick(P_CS, 8'hc3);
    reset = 1'b1;
    note(3, 32'h0000_0001, 32'h0000_0000);
    tick(12'h000, 8'h80);
    reset = 1'b0;
    rd(csm_pkg::CSM_SEL_CTRL, 32'h0000_0000);
    give_verdict();
  end
endmodule : testbench
